// [rtl/frame_dma_engine.v]
/*
  frame_dma_engine: ten-channel descriptor driven frame mover between two cpu
  port groups and host memory, with a plain software register port.
  assumes: the memory master port is answered by a one-request-at-a-time
  outbound path on ref_clk (mem_ack pulses once per request); the cpu port
  streams run on ref_clk; software configures the port groups beforehand.
*/
`timescale 1ns/100ps
`include "frame_dma_regs.vh"

module frame_dma_engine (
  // clock and reset
  input  wire        ref_clk,
  input  wire        rst_n,
  // software register port
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // outbound memory master
  output reg         mem_req,
  output reg         mem_we,
  output reg  [31:0] mem_addr,
  output reg  [31:0] mem_wdata,
  input  wire        mem_ack,
  input  wire [31:0] mem_rdata,
  // extraction streams, one lane per port group
  input  wire [1:0]  xtr_valid,
  input  wire [63:0] xtr_data,
  input  wire [63:0] xtr_ifh,
  input  wire [1:0]  xtr_eof,
  output reg  [1:0]  xtr_ready,
  // injection streams, one valid per port group, shared data
  output reg  [1:0]  inj_valid,
  output reg  [31:0] inj_data,
  output reg         inj_sof,
  output reg         inj_eof,
  output reg         inj_fcs_upd,
  input  wire [1:0]  inj_ready,
  // event summary
  output reg         evt_pending
);

  // one-hot engine states
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_RD   = 7'h02;
  localparam [6:0] S_XGET = 7'h04;
  localparam [6:0] S_XWR  = 7'h08;
  localparam [6:0] S_IRD  = 7'h10;
  localparam [6:0] S_IPUT = 7'h20;
  localparam [6:0] S_WB   = 7'h40;

  reg                 rst_s1_r;
  reg                 rst_sync_n;
  reg  [6:0]          state_r;
  reg  [3:0]          cur_r;
  reg  [1:0]          didx_r;
  reg  [31:0]         d_desc_r;
  reg  [31:0]         d_next_r;
  reg  [31:0]         d_datap_r;
  reg  [15:0]         d_datal_r;
  reg  [31:0]         d_stat_r;
  reg  [`POS_W-1:0]   pos_r;
  reg                 blk_sof_r;
  reg                 blk_eof_r;
  reg  [1:0]          xmid_r;
  reg  [1:0]          lock_r;
  reg  [3:0]          own_r [0:1];
  reg  [31:0]         llp_r [0:`NUM_CH-1];
  reg  [2:0]          prio_r [0:`NUM_CH-1];
  reg  [`NUM_CH-1:0]  grp_r;
  reg  [`NUM_CH-1:0]  act_r;
  reg  [`NUM_CH-1:0]  dis_r;
  reg  [`NUM_CH-1:0]  frm_r;
  reg  [`NUM_CH-1:0]  llpev_r;
  reg  [`NUM_CH-1:0]  frm_ena_r;
  reg  [`NUM_CH-1:0]  llp_ena_r;
  reg  [3:0]          man_cfg_r;

  reg  [`NUM_CH-1:0]  elig;
  reg                 win_ok;
  reg  [3:0]          win;
  reg  [2:0]          best;
  reg  [19:0]         st_vec;
  reg  [31:0]         rd_mux;
  integer             i;

  wire                is_xtr   = (cur_r < `NUM_XTR);
  wire                xport    = cur_r[0];
  wire                igrp     = grp_r[cur_r];
  wire [`POS_W-1:0]   pos_inc  = pos_r + 1'b1;
  wire [15:0]         pos_byt  = {pos_inc, 2'b00};
  wire                blk_last = is_xtr ? (pos_byt >= d_datal_r) : (pos_byt >= d_stat_r[15:0]);
  wire [31:0]         blk_addr = d_datap_r + {16'h0000, pos_r, 2'b00};
  wire                wb_done  = (state_r == S_WB) && mem_ack;
  wire [`NUM_CH-1:0]  cur_oh   = {{(`NUM_CH-1){1'b0}}, 1'b1} << cur_r;
  wire                is_null  = (d_next_r == `NULL_PTR);
  wire [`NUM_CH-1:0]  ident    = (frm_r & frm_ena_r) | (llpev_r & llp_ena_r);
  wire                man_on   = man_cfg_r[`MAN_ENA_BIT];
  wire                man_grp  = man_cfg_r[`MAN_GRP_BIT];
  wire                cfg_hit  = ((reg_addr & `OFF_BLOCK_MASK) == `OFF_CFG_BASE);
  wire                llp_hit  = ((reg_addr & `OFF_BLOCK_MASK) == `OFF_LLP_BASE);
  wire [3:0]          reg_ch   = reg_addr[5:2];

  // channel bookkeeping updates; a hardware set always beats a software clear
  wire [`NUM_CH-1:0]  act_set  = (reg_wr && reg_addr == `OFF_ACTIVATE) ? reg_wdata[`NUM_CH-1:0] : {`NUM_CH{1'b0}};
  wire [`NUM_CH-1:0]  dis_set  = (reg_wr && reg_addr == `OFF_DISABLE) ? reg_wdata[`NUM_CH-1:0] : {`NUM_CH{1'b0}};
  wire [`NUM_CH-1:0]  frm_clr  = (reg_wr && reg_addr == `OFF_INTR_FRM) ? reg_wdata[`NUM_CH-1:0] : {`NUM_CH{1'b0}};
  wire [`NUM_CH-1:0]  llp_clr  = (reg_wr && reg_addr == `OFF_INTR_LLP) ? reg_wdata[`NUM_CH-1:0] : {`NUM_CH{1'b0}};
  wire [`NUM_CH-1:0]  act_clr  = (wb_done && (is_null || dis_r[cur_r])) ? cur_oh : {`NUM_CH{1'b0}};
  wire [`NUM_CH-1:0]  frm_set  = (wb_done && blk_eof_r) ? cur_oh : {`NUM_CH{1'b0}};
  wire [`NUM_CH-1:0]  llp_set  = (wb_done && is_null) ? cur_oh : {`NUM_CH{1'b0}};

  // status word written back: extraction reports what it stored, injection marks done;
  // extraction loads it as its last write is acked, so the byte count already includes that word; injection loads it as the group accepts its last word
  wire [31:0] stat_wr = is_xtr ?
    {d_stat_r[31:`STAT_OFS_LSB], 2'b00, blk_eof_r, blk_sof_r, pos_byt} :
    {d_stat_r[31:`STAT_OFS_LSB], 1'b1, d_stat_r[`STAT_ABORT:`STAT_SOF], d_stat_r[15:0]};

  // reset release through two flops
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_r   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_s1_r   <= 1'b1;
      rst_sync_n <= rst_s1_r;
    end
  end

  // which channels could use the engine right now
  always @* begin
    elig = {`NUM_CH{1'b0}};
    for (i = 0; i < `NUM_CH; i = i + 1) begin
      if (i < `NUM_XTR)
        elig[i] = act_r[i] && xtr_valid[i];
      else
        elig[i] = act_r[i] && (!lock_r[grp_r[i]] || own_r[grp_r[i]] == i[3:0]);
    end
  end

  // strict priority; ascending scan with >= lets the higher number win ties
  always @* begin
    win_ok = 1'b0;
    win    = 4'h0;
    best   = 3'h0;
    for (i = 0; i < `NUM_CH; i = i + 1) begin
      if (elig[i] && (!win_ok || prio_r[i] >= best)) begin
        win_ok = 1'b1;
        win    = i[3:0];
        best   = prio_r[i];
      end
    end
  end

  // per-channel state readback, two bits each
  always @* begin
    for (i = 0; i < `NUM_CH; i = i + 1) begin
      if (!act_r[i])
        st_vec[2*i +: 2] = `ST_DISABLED;
      else if (cur_r == i[3:0] && (state_r == S_RD || state_r == S_WB))
        st_vec[2*i +: 2] = `ST_UPDATING;
      else
        st_vec[2*i +: 2] = `ST_ACTIVE;
    end
  end

  // register read multiplexer; unmapped addresses read zero
  always @* begin
    rd_mux = 32'h0000_0000;
    if (reg_addr == `OFF_ACTIVATE)
      rd_mux = {22'h00_0000, act_r};
    else if (reg_addr == `OFF_DISABLE)
      rd_mux = {22'h00_0000, dis_r};
    else if (reg_addr == `OFF_STATE)
      rd_mux = {12'h000, st_vec};
    else if (reg_addr == `OFF_INTR_FRM)
      rd_mux = {22'h00_0000, frm_r};
    else if (reg_addr == `OFF_INTR_LLP)
      rd_mux = {22'h00_0000, llpev_r};
    else if (reg_addr == `OFF_FRM_ENA)
      rd_mux = {22'h00_0000, frm_ena_r};
    else if (reg_addr == `OFF_LLP_ENA)
      rd_mux = {22'h00_0000, llp_ena_r};
    else if (reg_addr == `OFF_IDENT)
      rd_mux = {22'h00_0000, ident};
    else if (reg_addr == `OFF_MAN_CFG)
      rd_mux = {28'h000_0000, man_cfg_r};
    else if (reg_addr == `OFF_MAN_XTR)
      rd_mux = man_grp ? xtr_data[63:32] : xtr_data[31:0];
    else if (cfg_hit && reg_ch < `NUM_CH)
      rd_mux = {27'h000_0000, grp_r[reg_ch], 1'b0, prio_r[reg_ch]};
    else if (llp_hit && reg_ch < `NUM_CH)
      rd_mux = llp_r[reg_ch];
  end

  // registers, descriptor engine and stream handshakes
  always @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_r     <= S_IDLE;
      cur_r       <= 4'h0;
      didx_r      <= 2'h0;
      d_desc_r    <= 32'h0000_0000;
      d_next_r    <= 32'h0000_0000;
      d_datap_r   <= 32'h0000_0000;
      d_datal_r   <= 16'h0000;
      d_stat_r    <= 32'h0000_0000;
      pos_r       <= {`POS_W{1'b0}};
      blk_sof_r   <= 1'b0;
      blk_eof_r   <= 1'b0;
      xmid_r      <= 2'h0;
      lock_r      <= 2'h0;
      own_r[0]    <= 4'h0;
      own_r[1]    <= 4'h0;
      grp_r       <= {`NUM_CH{1'b0}};
      act_r       <= {`NUM_CH{1'b0}};
      dis_r       <= {`NUM_CH{1'b0}};
      frm_r       <= {`NUM_CH{1'b0}};
      llpev_r     <= {`NUM_CH{1'b0}};
      frm_ena_r   <= {`NUM_CH{1'b0}};
      llp_ena_r   <= {`NUM_CH{1'b0}};
      man_cfg_r   <= 4'h0;
      reg_rdata   <= 32'h0000_0000;
      mem_req     <= 1'b0;
      mem_we      <= 1'b0;
      mem_addr    <= 32'h0000_0000;
      mem_wdata   <= 32'h0000_0000;
      xtr_ready   <= 2'h0;
      inj_valid   <= 2'h0;
      inj_data    <= 32'h0000_0000;
      inj_sof     <= 1'b0;
      inj_eof     <= 1'b0;
      inj_fcs_upd <= 1'b0;
      evt_pending <= 1'b0;
      for (i = 0; i < `NUM_CH; i = i + 1) begin
        llp_r[i]  <= 32'h0000_0000;
        prio_r[i] <= 3'h0;
      end
    end else begin
      xtr_ready   <= 2'h0;
      reg_rdata   <= reg_rd ? rd_mux : 32'h0000_0000;
      evt_pending <= |ident;
      act_r       <= (act_r & ~act_clr) | act_set;
      dis_r       <= (dis_r & ~act_clr & ~act_set) | dis_set;
      frm_r       <= (frm_r & ~frm_clr) | frm_set;
      llpev_r     <= (llpev_r & ~llp_clr) | llp_set;
      // software writes
      if (reg_wr) begin
        if (reg_addr == `OFF_FRM_ENA)
          frm_ena_r <= reg_wdata[`NUM_CH-1:0];
        if (reg_addr == `OFF_LLP_ENA)
          llp_ena_r <= reg_wdata[`NUM_CH-1:0];
        if (reg_addr == `OFF_MAN_CFG)
          man_cfg_r <= reg_wdata[3:0];
        if (cfg_hit && reg_ch < `NUM_CH) begin
          prio_r[reg_ch] <= reg_wdata[`CFG_PRIO_MSB:0];
          grp_r[reg_ch]  <= reg_wdata[`CFG_GRP_BIT];
        end
        if (llp_hit && reg_ch < `NUM_CH)
          llp_r[reg_ch] <= reg_wdata;
        if (reg_addr == `OFF_MAN_INJ && man_on) begin
          inj_valid[man_grp] <= 1'b1;
          inj_data           <= reg_wdata;
          inj_sof            <= man_cfg_r[`MAN_SOF_BIT];
          inj_eof            <= man_cfg_r[`MAN_EOF_BIT];
          inj_fcs_upd        <= man_cfg_r[`MAN_SOF_BIT] && reg_wdata[`IFH_FCS_BIT];
        end
      end
      // manual extraction pops a word on each data read
      if (reg_rd && reg_addr == `OFF_MAN_XTR && man_on && xtr_valid[man_grp])
        xtr_ready[man_grp] <= 1'b1;
      // an injection word leaves when its group accepts it
      for (i = 0; i < `NUM_XTR; i = i + 1) begin
        if (inj_valid[i] && inj_ready[i])
          inj_valid[i] <= 1'b0;
      end
      // descriptor engine: one memory request outstanding at most
      case (state_r)
        S_IDLE: begin
          if (!man_on && win_ok) begin
            cur_r    <= win;
            didx_r   <= 2'h0;
            d_desc_r <= llp_r[win];
            mem_req  <= 1'b1;
            mem_we   <= 1'b0;
            mem_addr <= llp_r[win];
            state_r  <= S_RD;
          end
        end
        S_RD: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            case (didx_r)
              2'h0:    d_next_r  <= mem_rdata;
              2'h1:    d_datap_r <= mem_rdata;
              2'h2:    d_datal_r <= mem_rdata[15:0];
              default: d_stat_r  <= mem_rdata;
            endcase
            if (didx_r == `DESC_LAST_IDX) begin
              pos_r     <= {`POS_W{1'b0}};
              blk_sof_r <= 1'b0;
              blk_eof_r <= is_xtr ? 1'b0 : mem_rdata[`STAT_EOF];
              if (is_xtr) begin
                state_r <= S_XGET;
              end else begin
                mem_req  <= 1'b1;
                mem_addr <= d_datap_r;
                state_r  <= S_IRD;
              end
            end else begin
              didx_r   <= didx_r + 2'h1;
              mem_req  <= 1'b1;
              mem_addr <= mem_addr + `WORD_BYTES;
            end
          end
        end
        S_XGET: begin
          if (xtr_valid[xport]) begin
            if (!xmid_r[xport]) begin
              mem_wdata      <= xport ? xtr_ifh[63:32] : xtr_ifh[31:0];
              blk_sof_r      <= 1'b1;
              xmid_r[xport]  <= 1'b1;
            end else begin
              mem_wdata        <= xport ? xtr_data[63:32] : xtr_data[31:0];
              blk_eof_r        <= xtr_eof[xport];
              xtr_ready[xport] <= 1'b1;
            end
            mem_req  <= 1'b1;
            mem_we   <= 1'b1;
            mem_addr <= blk_addr;
            state_r  <= S_XWR;
          end
        end
        S_XWR: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            pos_r   <= pos_inc;
            if (blk_eof_r || blk_last) begin
              if (blk_eof_r)
                xmid_r[xport] <= 1'b0;
              mem_req   <= 1'b1;
              mem_addr  <= d_desc_r + `DESC_STAT_OFF;
              mem_wdata <= stat_wr;
              state_r   <= S_WB;
            end else begin
              state_r <= S_XGET;
            end
          end
        end
        S_IRD: begin
          if (mem_ack) begin
            mem_req         <= 1'b0;
            inj_valid[igrp] <= 1'b1;
            inj_data        <= mem_rdata;
            inj_sof         <= (pos_r == {`POS_W{1'b0}}) && d_stat_r[`STAT_SOF];
            inj_eof         <= blk_last && d_stat_r[`STAT_EOF];
            inj_fcs_upd     <= (pos_r == {`POS_W{1'b0}}) && d_stat_r[`STAT_SOF] && mem_rdata[`IFH_FCS_BIT];
            if (pos_r == {`POS_W{1'b0}} && d_stat_r[`STAT_SOF]) begin
              lock_r[igrp] <= 1'b1;
              own_r[igrp]  <= cur_r;
            end
            state_r <= S_IPUT;
          end
        end
        S_IPUT: begin
          if (inj_valid[igrp] && inj_ready[igrp]) begin
            pos_r <= pos_inc;
            if (inj_eof)
              lock_r[igrp] <= 1'b0;
            mem_req <= 1'b1;
            mem_we  <= blk_last;
            if (blk_last) begin
              mem_addr  <= d_desc_r + `DESC_STAT_OFF;
              mem_wdata <= stat_wr;
              state_r   <= S_WB;
            end else begin
              mem_addr <= blk_addr + `WORD_BYTES;
              state_r  <= S_IRD;
            end
          end
        end
        S_WB: begin
          // write and status word were loaded with the request, so they stand until ack
          if (mem_ack) begin
            mem_req        <= 1'b0;
            mem_we         <= 1'b0;
            llp_r[cur_r]   <= d_next_r;
            state_r        <= S_IDLE;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

endmodule // frame_dma_engine

// [rtl/frame_dma_regs.vh]
/*
  register offsets, field positions and encodings of the frame dma engine.
  assumes a word-addressed register port with 8-bit byte addresses.
*/
`ifndef FRAME_DMA_REGS_VH
`define FRAME_DMA_REGS_VH

// channel layout
`define NUM_CH          10
`define NUM_XTR         2
`define CH_IDX_W        4
`define POS_W           14

// register byte addresses
`define OFF_ACTIVATE    8'h00
`define OFF_DISABLE     8'h04
`define OFF_STATE       8'h08
`define OFF_INTR_FRM    8'h0C
`define OFF_INTR_LLP    8'h10
`define OFF_FRM_ENA     8'h14
`define OFF_LLP_ENA     8'h18
`define OFF_IDENT       8'h1C
`define OFF_MAN_CFG     8'h20
`define OFF_MAN_XTR     8'h24
`define OFF_MAN_INJ     8'h28
`define OFF_CFG_BASE    8'h40
`define OFF_LLP_BASE    8'h80
`define OFF_BLOCK_MASK  8'hC0

// channel_config fields
`define CFG_PRIO_MSB    2
`define CFG_GRP_BIT     4

// manual configuration fields
`define MAN_ENA_BIT     0
`define MAN_GRP_BIT     1
`define MAN_SOF_BIT     2
`define MAN_EOF_BIT     3

// descriptor layout
`define DESC_LAST_IDX   2'h3
`define DESC_STAT_OFF   32'h0000_000C
`define WORD_BYTES      32'h0000_0004
`define NULL_PTR        32'h0000_0000
`define STAT_SOF        16
`define STAT_EOF        17
`define STAT_ABORT      18
`define STAT_PD         19
`define STAT_OFS_LSB    20

// internal_frame_header bit asking for fcs recompute
`define IFH_FCS_BIT     0

// per-channel state readback codes
`define ST_DISABLED     2'h0
`define ST_UPDATING     2'h1
`define ST_ACTIVE       2'h2

`endif

// [bench/frame_dma_props.sv]
/*
  frame_dma_props: port checks on frame_dma_engine.
  assumes one clock, rst_n async active low.
*/
`timescale 1ns/100ps
module frame_dma_props (
  // clock, reset
  input wire        ref_clk,
  input wire        rst_n,
  // register and memory ports
  input wire        reg_rd,
  input wire [31:0] reg_rdata,
  input wire        mem_req,
  input wire        mem_we,
  input wire [31:0] mem_addr,
  input wire [31:0] mem_wdata,
  input wire        mem_ack,
  // streams
  input wire [1:0]  xtr_valid,
  input wire [1:0]  xtr_ready,
  input wire [1:0]  inj_valid,
  input wire [31:0] inj_data,
  input wire        inj_sof,
  input wire        inj_fcs_upd,
  input wire [1:0]  inj_ready
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // a request stands unchanged until its ack
  mem_hold_a: assert property (
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we) && $stable(mem_wdata))
    else $error("memory request changed before ack");
  // an acked request is released, not issued twice
  mem_next_a: assert property (
    mem_ack |=> !mem_req || mem_addr != $past(mem_addr) || mem_we != $past(mem_we))
    else $error("memory request repeated after ack");
  // read data stand only in the cycle after a read
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data outside read cycle");
  // a pop needs a word offered on that lane
  xtr0_pop_a: assert property (xtr_ready[0] |-> $past(xtr_valid[0]))
    else $error("lane 0 popped without a word");
  xtr1_pop_a: assert property (xtr_ready[1] |-> $past(xtr_valid[1], 1))
    else $error("lane 1 popped without a word");
  // an offered word holds until accepted
  inj_hold_a: assert property (
    |(inj_valid & ~inj_ready) |=> inj_valid == $past(inj_valid) && $stable(inj_data) && $stable(inj_sof))
    else $error("injection word dropped before accept");
  // shared data lines serve one group at a time
  inj_one_a: assert property (inj_valid != 2'b11)
    else $error("both injection groups offered");
  // fcs request rides only on a start word
  inj_fcs_a: assert property (|inj_valid && inj_fcs_upd |-> inj_sof)
    else $error("fcs request off the start word");

  wr_done_c: cover property (mem_req && mem_we && mem_ack);
  inj_take_c: cover property (|(inj_valid & inj_ready));
  pop_c: cover property (|xtr_ready);
endmodule // frame_dma_props

bind frame_dma_engine frame_dma_props i_props (
  .ref_clk(ref_clk), .rst_n(rst_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
  .mem_ack(mem_ack), .xtr_valid(xtr_valid), .xtr_ready(xtr_ready), .inj_valid(inj_valid),
  .inj_data(inj_data), .inj_sof(inj_sof), .inj_fcs_upd(inj_fcs_upd), .inj_ready(inj_ready));

// [bench/host_mem_model.sv]
/*
  host_mem_model: word memory behind the outbound master port.
  assumes one request at a time; lat adds wait cycles before mem_ack.
*/
`timescale 1ns/100ps
module host_mem_model (
  // clock, reset
  input  wire        ref_clk,
  input  wire        rst_n,
  // answer delay
  input  wire [3:0]  lat,
  // master port
  input  wire        mem_req,
  input  wire        mem_we,
  input  wire [31:0] mem_addr,
  input  wire [31:0] mem_wdata,
  output reg         mem_ack,
  output reg  [31:0] mem_rdata
);
  reg [31:0] mem [0:255];
  reg [3:0]  wait_r;

  // no ack in the cycle after an ack: the master still shows the acked request then
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_ack   <= 1'b0;
      mem_rdata <= 32'h5A5A_A5A5;
      wait_r    <= 4'h0;
    end else begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;  // inverted each cycle, so the read word shows again only every other cycle
      if (mem_req && !mem_ack) begin
        if (wait_r == lat) begin
          mem_ack <= 1'b1;
          wait_r  <= 4'h0;
          if (mem_we)
            mem[mem_addr[9:2]] <= mem_wdata;
          else
            mem_rdata <= mem[mem_addr[9:2]];
        end else
          wait_r <= wait_r + 4'h1;
      end
    end
  end
endmodule // host_mem_model

// [bench/test_frame_dma_engine.sv]
/*
  test_frame_dma_engine: self-checking bench with a host memory model.
  assumes the register map of frame_dma_regs.vh.
*/
`timescale 1ns/100ps
`include "frame_dma_regs.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_frame_dma_engine;
  typedef struct {logic [7:0] a; logic [31:0] d, e;} row_t;
  // stimulus
  reg         ref_clk, rst_n, reg_wr, reg_rd;
  reg  [7:0]  reg_addr;
  reg  [31:0] reg_wdata;
  reg  [1:0]  xtr_valid, xtr_eof, inj_ready;
  reg  [63:0] xtr_data, xtr_ifh;
  reg  [3:0]  lat;
  // responses
  wire [31:0] reg_rdata, mem_addr, mem_wdata, mem_rdata, inj_data;
  wire        mem_req, mem_we, mem_ack, inj_sof, inj_eof, inj_fcs_upd, evt_pending;
  wire [1:0]  xtr_ready, inj_valid;
  // bookkeeping
  int          miscompares, checks, pops, i;
  logic [31:0] got, inj_q[$], rd_q[$];
  logic [3:0]  flg_q[$];
  row_t        rows[9];
  logic [7:0]  rst_regs[4] = '{`OFF_DISABLE, `OFF_LLP_ENA, 8'h48, 8'h84};
  logic [31:0] exp_d[4] = '{32'h0000_0000, 32'hBEEF_0003, 32'h0000_0001, 32'hBEEF_0002};
  logic [3:0]  exp_f[4] = '{4'b1100, 4'b1010, 4'b1101, 4'b1010};

  frame_dma_engine i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .xtr_valid(xtr_valid), .xtr_data(xtr_data), .xtr_ifh(xtr_ifh), .xtr_eof(xtr_eof),
    .xtr_ready(xtr_ready), .inj_valid(inj_valid), .inj_data(inj_data), .inj_sof(inj_sof),
    .inj_eof(inj_eof), .inj_fcs_upd(inj_fcs_upd), .inj_ready(inj_ready), .evt_pending(evt_pending));
  host_mem_model i_mem (.ref_clk(ref_clk), .rst_n(rst_n), .lat(lat), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // stall every other cycle; log accepted words, memory reads and lane 1 pops
  always @(posedge ref_clk) begin
    inj_ready <= ~inj_ready;
    if (|(inj_valid & inj_ready)) begin
      inj_q.push_back(inj_data);
      flg_q.push_back({inj_valid[1], inj_sof, inj_eof, inj_fcs_upd});
    end
    if (mem_ack && !mem_we)
      rd_q.push_back(mem_addr);
    if (xtr_ready[1])
      pops++;
  end

  task automatic step();
    @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a, got);
    `CHK(got, e)
  endtask
  // descriptor with a NULL next pointer and a 16-byte block
  task automatic desc(input logic [31:0] a, p, s);
    i_mem.mem[a[9:2]] = `NULL_PTR;
    i_mem.mem[a[9:2] + 8'h01] = p;
    i_mem.mem[a[9:2] + 8'h02] = 32'h0000_0010;
    i_mem.mem[a[9:2] + 8'h03] = s;
  endtask
  task automatic reset_dut();
    rst_n <= 1'b0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic final_report();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // bounded poll until every channel reads disabled
  task automatic wait_idle();
    for (int k = 0; k < 300; k++) begin
      rd(`OFF_STATE, got);
      if (got === 32'h0000_0000)
        return;
    end
    `CHK(got, 32'h0000_0000)
    final_report();
  endtask

  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata, xtr_valid, xtr_eof, xtr_data, xtr_ifh} = '0;
    rst_n = 1'b0;
    inj_ready = 2'b01;
    lat = 4'h3;
    rows[0] = '{8'h48, 32'hFFFF_FFFF, 32'h0000_0017};
    rows[1] = '{8'h64, 32'h0000_0012, 32'h0000_0012};
    rows[2] = '{8'h40, 32'h0000_0005, 32'h0000_0005};
    rows[3] = '{8'h68, 32'hFFFF_FFFF, 32'h0000_0000};  // channel 10 absent
    rows[4] = '{8'h84, 32'h0000_0340, 32'h0000_0340};
    rows[5] = '{8'hA8, 32'hFFFF_FFFF, 32'h0000_0000};
    rows[6] = '{8'h30, 32'hFFFF_FFFF, 32'h0000_0000};  // unmapped
    rows[7] = '{`OFF_LLP_ENA, 32'hFFFF_FFFF, 32'h0000_03FF};
    rows[8] = '{`OFF_DISABLE, 32'hFFFF_FFFF, 32'h0000_03FF};
    reset_dut();
    for (i = 0; i < 9; i++) begin
      wr(rows[i].a, rows[i].d);
      rchk(rows[i].a, rows[i].e);
    end
    // second reset in mid-run brings back defaults
    reset_dut();
    foreach (rst_regs[j])
      rchk(rst_regs[j], 32'h0000_0000);
    // extraction on channel 0, slow memory
    desc(32'h0000_0100, 32'h0000_0200, 32'h0000_0000);
    wr(`OFF_FRM_ENA, 32'h0000_0001);
    wr(`OFF_LLP_BASE, 32'h0000_0100);
    wr(`OFF_ACTIVATE, 32'h0000_0001);
    xtr_valid <= 2'b01;
    xtr_eof   <= 2'b01;
    xtr_ifh   <= 64'h0000_0000_1F2E_3D4C;
    xtr_data  <= 64'h0000_0000_CAFE_0001;
    // a disable request mid-transfer leaves the channel active until writeback
    wr(`OFF_DISABLE, 32'h0000_0001);
    rchk(`OFF_ACTIVATE, 32'h0000_0001);
    for (i = 0; i < 200 && xtr_ready[0] !== 1'b1; i++)
      step();
    xtr_valid <= 2'b00;
    `CHK(xtr_ready[0], 1'b1)
    wait_idle();
    `CHK(i_mem.mem[8'h80], 32'h1F2E_3D4C)
    `CHK(i_mem.mem[8'h81], 32'hCAFE_0001)
    `CHK(i_mem.mem[8'h43], 32'h0003_0008)
    rchk(`OFF_DISABLE, 32'h0000_0000);
    rchk(`OFF_INTR_LLP, 32'h0000_0001);
    rchk(`OFF_LLP_BASE, 32'h0000_0000);
    rchk(`OFF_IDENT, 32'h0000_0001);
    `CHK(evt_pending, 1'b1)
    // clear frame-done; chain-end stays set but masked
    wr(`OFF_INTR_FRM, 32'h0000_0001);
    rchk(`OFF_IDENT, 32'h0000_0000);
    `CHK(evt_pending, 1'b0)
    wr(`OFF_LLP_ENA, 32'h0000_0001);
    rchk(`OFF_IDENT, 32'h0000_0001);
    wr(`OFF_INTR_LLP, 32'h0000_0001);
    rchk(`OFF_INTR_LLP, 32'h0000_0000);
    // two equal-priority injection channels race for group 1, prompt memory
    lat = 4'h0;
    desc(32'h0000_0300, 32'h0000_0380, 32'h0003_0008);
    desc(32'h0000_0340, 32'h0000_03C0, 32'h0003_0008);
    i_mem.mem[8'hE0] = 32'h0000_0001;
    i_mem.mem[8'hE1] = 32'hBEEF_0002;
    i_mem.mem[8'hF0] = 32'h0000_0000;
    i_mem.mem[8'hF1] = 32'hBEEF_0003;
    wr(`OFF_CFG_BASE + 8'h08, 32'h0000_0010);
    wr(`OFF_CFG_BASE + 8'h0C, 32'h0000_0010);
    wr(`OFF_LLP_BASE + 8'h08, 32'h0000_0300);
    wr(`OFF_LLP_BASE + 8'h0C, 32'h0000_0340);
    rd_q.delete();
    wr(`OFF_ACTIVATE, 32'h0000_000C);
    wait_idle();
    `CHK(rd_q[0], 32'h0000_0340)
    for (i = 0; i < 4; i++) begin
      `CHK(inj_q[i], exp_d[i])
      `CHK(flg_q[i], exp_f[i])
    end
    `CHK(i_mem.mem[8'hC3], 32'h000B_0008)
    `CHK(i_mem.mem[8'hD3], 32'h000B_0008)
    rchk(`OFF_INTR_FRM, 32'h0000_000C);
    // manual mode, group 1
    wr(`OFF_MAN_CFG, 32'h0000_000F);
    wr(`OFF_MAN_INJ, 32'h0000_0001);
    for (i = 0; i < 50 && inj_q.size() < 5; i++)
      step();
    `CHK(inj_q[4], 32'h0000_0001)
    `CHK(flg_q[4], 4'b1111)
    xtr_valid <= 2'b10;
    xtr_data  <= 64'h5A5A_0005_0000_0000;
    rchk(`OFF_MAN_XTR, 32'h5A5A_0005);
    xtr_valid <= 2'b00;
    repeat (2) step();
    `CHK(pops, 1)
    final_report();
  end
endmodule // test_frame_dma_engine
